// >>> logic/reset_combiner_pkg.sv
package reset_combiner_pkg;
  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [11:0] cause_register_addr = 12'h000;
  localparam logic [11:0] source_status_addr  = 12'h004;
  localparam int          addr_width          = 12;
  localparam int          data_width          = 32;
  localparam int          reg_width           = 16;

  // --------------------------------------------------------------------------
  // Field positions of the reset cause register
  // --------------------------------------------------------------------------
  localparam int power_on_bit       = 0;
  localparam int brown_out_bit      = 1;
  localparam int idle_wake_bit      = 2;
  localparam int sleep_wake_bit     = 3;
  localparam int watchdog_bit       = 4;
  localparam int soft_wdt_en_bit    = 5;
  localparam int soft_instr_bit     = 6;
  localparam int ext_pin_bit        = 7;
  localparam int regulator_bit      = 8;
  localparam int config_mismatch_bit = 9;
  localparam int illegal_bit        = 14;
  localparam int trap_conflict_bit  = 15;

  localparam logic [15:0] implemented_mask = 16'hC3FF;
  localparam logic [15:0] power_on_value   = 16'h0003;
  localparam logic [15:0] reset_vector     = 16'h0000;
  localparam logic [31:0] bus_zero         = 32'h0000_0000;

  typedef enum logic [1:0] {
    st_idle,
    st_access
  } bus_state_t;
endpackage : reset_combiner_pkg

// >>> logic/reset_source_combiner.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] Any active source asserts system reset line.
// [R2] Accept eight listed reset request inputs.
// [R3] Illegal opcode, uninit register, security set bit 14.
// [R4] Each reset type sets its own flag.
// [R5] Power-on clears all flags except bits 0 and 1.
// [R6] Software may set or clear any flag.
// [R7] Software flag writes never cause reset.
// [R8] Trap conflict sets bit 15.
// [R9] Configuration mismatch sets bit 9.
// [R10] Master clear pin sets bit 7.
// [R11] Watchdog timeout sets bit 4.
// [R12] Sleep entry sets wake flag bit 3.
// [R13] Idle entry sets wake flag bit 2.
// [R14] Brown-out sets bit 1; one after power-on.
// [R15] Power-on sets bit 0.
// [R16] Bit 8 keeps regulator active in sleep.
// [R17] Bit 5 or fuse enables the watchdog.
// [R18] System reset drives peripheral reset outputs; the module has none, only system_reset_line.
// [R19] Software clears flags after reading them.
// [R20] Instruction reset sets bit 6; flags persist.
// [R21] Instruction reset releases line next cycle.
// [R22] Watchdog in sleep or idle only wakes.
// [R23] After release, fetch starts at vector zero.
module reset_source_combiner
  import reset_combiner_pkg::*;
(
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   clk_en,
  input  wire logic [reset_combiner_pkg::addr_width-1:0] paddr,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [reset_combiner_pkg::data_width-1:0] pwdata,
  input  wire logic [3:0]                             pstrb,
  output logic      [reset_combiner_pkg::data_width-1:0] prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   power_on_req,
  input  wire logic                                   brown_out_req,
  input  wire logic                                   master_clear_pin_n,
  input  wire logic                                   reset_instr_req,
  input  wire logic                                   watchdog_timeout,
  input  wire logic                                   config_mismatch_req,
  input  wire logic                                   trap_conflict_req,
  input  wire logic                                   illegal_opcode,
  input  wire logic                                   uninit_reg_addr,
  input  wire logic                                   security_violation,
  input  wire logic                                   sleep_entered,
  input  wire logic                                   idle_entered,
  input  wire logic                                   low_power_active,
  input  wire logic                                   oscillator_ready,
  input  wire logic                                   fuse_watchdog_enable,
  output logic                                        system_reset_line,
  output logic                                        watchdog_enabled,
  output logic                                        regulator_active,
  output logic                                        watchdog_wake,
  output logic                                        fetch_start,
  output logic      [reset_combiner_pkg::reg_width-1:0] fetch_address
);
  import reset_combiner_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    bus_state_t           bus;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 err;
    logic [15:0]          cause;
    logic                 sys_rst;
    logic                 wdt_en;
    logic                 reg_act;
    logic                 wake;
    logic                 fetch;
    logic [15:0]          fetch_addr;
  } state_t;

  state_t cur;
  state_t next_state;

  logic        illegal_req;
  logic        wdt_reset_req;
  logic        any_source;
  logic        bus_write;
  logic        bus_read;
  logic        addr_ok;
  logic [15:0] wmask;
  logic [15:0] hw_set;

  assign illegal_req   = illegal_opcode | uninit_reg_addr
                         | security_violation; // [R3]
  // A timeout while asleep or idle wakes the core instead of resetting it.
  assign wdt_reset_req = watchdog_timeout & ~low_power_active; // [R22]
  assign any_source    = power_on_req | brown_out_req | ~master_clear_pin_n
                         | reset_instr_req | wdt_reset_req
                         | config_mismatch_req | trap_conflict_req
                         | illegal_req; // [R2]
  assign addr_ok   = (paddr == cause_register_addr)
                     || (paddr == source_status_addr);
  assign bus_write = psel & penable & pwrite & cur.ready;
  assign bus_read  = psel & ~penable & ~pwrite;
  assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_state = cur;
    hw_set     = 16'h0000;
    hw_set[brown_out_bit]       = brown_out_req; // [R14]
    hw_set[idle_wake_bit]       = idle_entered; // [R13]
    hw_set[sleep_wake_bit]      = sleep_entered; // [R12]
    hw_set[watchdog_bit]        = watchdog_timeout; // [R11]
    hw_set[soft_instr_bit]      = reset_instr_req; // [R20]
    hw_set[ext_pin_bit]         = ~master_clear_pin_n; // [R10]
    hw_set[config_mismatch_bit] = config_mismatch_req; // [R9]
    hw_set[illegal_bit]         = illegal_req; // [R3]
    hw_set[trap_conflict_bit]   = trap_conflict_req; // [R8]

    // Slave answers in the access phase with one wait-free cycle.
    next_state.ready = 1'b0;
    next_state.err   = 1'b0;
    unique case (cur.bus)
      st_idle:
      begin
        if (psel && !penable)
        begin
          next_state.bus   = st_access;
          next_state.ready = 1'b1;
          next_state.err   = !addr_ok;
          next_state.rdata = bus_zero;
          if (bus_read && paddr == cause_register_addr)
            next_state.rdata = {16'h0000, cur.cause};
          else if (bus_read && paddr == source_status_addr)
            next_state.rdata = {30'h0, cur.sys_rst, cur.wdt_en};
        end
      end
      st_access:
      begin
        next_state.bus = st_idle;
      end
    endcase

    // Software writes only touch the stored flags, never the reset line.
    if (bus_write && paddr == cause_register_addr)
      next_state.cause = ((cur.cause & ~wmask)
                          | (pwdata[15:0] & wmask))
                         & implemented_mask; // [R6] [R7] [R19]

    // Hardware events win over a clearing write in the same cycle.
    next_state.cause = next_state.cause | hw_set; // [R4] [R20]
    if (power_on_req)
    begin
      next_state.cause = power_on_value; // [R5] [R14] [R15]
    end

    next_state.sys_rst = any_source; // [R1] [R21]
    next_state.wdt_en  = fuse_watchdog_enable
                         | cur.cause[soft_wdt_en_bit]; // [R17]
    next_state.reg_act = cur.cause[regulator_bit]; // [R16]
    next_state.wake    = watchdog_timeout & low_power_active; // [R22]
    next_state.fetch   = cur.sys_rst & ~any_source
                         & oscillator_ready; // [R23]
    if (cur.sys_rst)
      next_state.fetch_addr = reset_vector; // [R18] [R23]
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur            <= '0;
      cur.cause      <= power_on_value; // [R15]
      cur.sys_rst    <= 1'b1;
      cur.bus        <= st_idle;
    end
    else if (clk_en)
    begin
      cur <= next_state;
    end
  end

  assign prdata            = cur.rdata;
  assign pready            = cur.ready;
  assign pslverr           = cur.err;
  assign system_reset_line = cur.sys_rst;
  assign watchdog_enabled  = cur.wdt_en;
  assign regulator_active  = cur.reg_act;
  assign watchdog_wake     = cur.wake;
  assign fetch_start       = cur.fetch;
  assign fetch_address     = cur.fetch_addr;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // All checks share the bus clock and are muted while reset is held.
  default clocking dc @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  a_source_asserts_reset: assert property ( // [R1]
    clk_en && any_source |=> system_reset_line)
    else $error("reset source did not assert the line");

  a_instr_release: assert property ( // [R21]
    clk_en && !any_source |=> !system_reset_line)
    else $error("reset line not released a cycle after sources fell");

  a_power_on_clear: assert property ( // [R5]
    clk_en && power_on_req |=> cur.cause == power_on_value)
    else $error("power-on did not leave only the power flags");

  a_power_on_flag: assert property ( // [R15]
    clk_en && power_on_req |=> cur.cause[power_on_bit])
    else $error("power-on flag not set");

  a_brown_out_flag: assert property ( // [R14]
    clk_en && brown_out_req |=> cur.cause[brown_out_bit])
    else $error("brown-out flag not set");

  a_trap_flag_set: assert property ( // [R8]
    clk_en && trap_conflict_req && !power_on_req
    |=> cur.cause[trap_conflict_bit])
    else $error("trap conflict flag not set");

  a_illegal_flag_set: assert property ( // [R3]
    clk_en && illegal_req && !power_on_req |=> cur.cause[illegal_bit])
    else $error("illegal condition flag not set");

  a_pin_flag_set: assert property ( // [R10]
    clk_en && !master_clear_pin_n && !power_on_req
    |=> cur.cause[ext_pin_bit])
    else $error("pin reset flag not set");

  a_mismatch_flag_set: assert property ( // [R9]
    clk_en && config_mismatch_req && !power_on_req
    |=> cur.cause[config_mismatch_bit])
    else $error("configuration mismatch flag not set");

  a_wdt_flag_set: assert property ( // [R11]
    clk_en && watchdog_timeout && !power_on_req
    |=> cur.cause[watchdog_bit])
    else $error("watchdog timeout flag not set");

  a_sleep_flag_set: assert property ( // [R12]
    clk_en && sleep_entered && !power_on_req
    |=> cur.cause[sleep_wake_bit])
    else $error("sleep wake flag not set");

  a_idle_flag_set: assert property ( // [R13]
    clk_en && idle_entered && !power_on_req
    |=> cur.cause[idle_wake_bit])
    else $error("idle wake flag not set");

  a_instr_flag_set: assert property ( // [R20]
    clk_en && reset_instr_req && !power_on_req
    |=> cur.cause[soft_instr_bit])
    else $error("instruction reset flag not set");

  a_flags_persist: assert property ( // [R20]
    clk_en && !power_on_req && !bus_write && cur.cause[trap_conflict_bit]
    |=> cur.cause[trap_conflict_bit])
    else $error("cause flag lost without a write");

  a_unused_bits_zero: assert property ( // [R6]
    cur.cause[13:10] == 4'h0)
    else $error("unimplemented cause bits became set");

  a_soft_write_safe: assert property ( // [R7]
    clk_en && bus_write && !any_source |=> !system_reset_line)
    else $error("register write caused a reset");

  a_wdt_enable: assert property ( // [R17]
    clk_en && fuse_watchdog_enable |=> watchdog_enabled)
    else $error("fuse did not force the watchdog on");

  a_regulator_follow: assert property ( // [R16]
    clk_en |=> regulator_active == $past(cur.cause[regulator_bit]))
    else $error("regulator control does not follow bit 8");

  a_sleep_wdt_wake: assert property ( // [R22]
    clk_en && watchdog_timeout && low_power_active && !power_on_req
    |=> watchdog_wake && cur.cause[watchdog_bit])
    else $error("watchdog in low power did not wake");

  a_wake_no_reset: assert property ( // [R22]
    clk_en && watchdog_timeout && low_power_active && !any_source
    |=> !system_reset_line)
    else $error("watchdog in low power reset the core");

  a_fetch_vector: assert property ( // [R23]
    fetch_start |-> fetch_address == reset_vector)
    else $error("fetch did not start at the reset vector");
endmodule : reset_source_combiner

// >>> tb/reset_source_combiner_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module reset_source_combiner_tb;
  import reset_combiner_pkg::*;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] req;
  logic        power_on_req, low_power_active, fuse_watchdog_enable;
  logic        system_reset_line, watchdog_enabled, regulator_active;
  logic        watchdog_wake, fetch_start, seen_line, seen_wake, seen_fetch;
  logic [15:0] fetch_address;
  int          n_fail, comparisons, k;
  int          pos [11] = '{1, 7, 6, 4, 9, 15, 14, 14, 14, 3, 2};

  reset_source_combiner DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_req(power_on_req), .brown_out_req(req[0]),
    .master_clear_pin_n(~req[1]), .reset_instr_req(req[2]),
    .watchdog_timeout(req[3]), .config_mismatch_req(req[4]),
    .trap_conflict_req(req[5]), .illegal_opcode(req[6]),
    .uninit_reg_addr(req[7]), .security_violation(req[8]),
    .sleep_entered(req[9]), .idle_entered(req[10]),
    .low_power_active(low_power_active), .oscillator_ready(1'b1),
    .fuse_watchdog_enable(fuse_watchdog_enable),
    .system_reset_line(system_reset_line),
    .watchdog_enabled(watchdog_enabled), .regulator_active(regulator_active),
    .watchdog_wake(watchdog_wake), .fetch_start(fetch_start),
    .fetch_address(fetch_address)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Sticky monitors catch one-cycle pulses that a later read would miss.
  always @(posedge pclk)
  begin
    if (system_reset_line === 1'b1) seen_line <= 1'b1;
    if (watchdog_wake === 1'b1) seen_wake <= 1'b1;
    if (fetch_start === 1'b1) seen_fetch <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16)
    begin
      n_fail++;
      final_report();
    end
  endtask : apb

  task pulse(input int n);
    @(posedge pclk);
    req[n] <= 1'b1;
    @(posedge pclk);
    req[n] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; req = 11'h0; power_on_req = 1'b0;
    low_power_active = 1'b0; fuse_watchdog_enable = 1'b0;
    seen_line = 1'b0; seen_wake = 1'b0; seen_fetch = 1'b0;
    n_fail = 0; comparisons = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(cause_register_addr, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0003)
    `CHK(seen_fetch, 1'b1)
    `CHK(fetch_address, 16'h0000)
    $display("test reset_values done");
    for (k = 0; k < 11; k++)
    begin
      apb(cause_register_addr, 1'b1, 32'h0);
      seen_line = 1'b0;
      pulse(k);
      `CHK(seen_line, (k < 9) ? 1'b1 : 1'b0)
      apb(cause_register_addr, 1'b0, 32'h0);
      `CHK(rd, 32'h1 << pos[k])
    end
    $display("test sources done");
    seen_line = 1'b0;
    apb(cause_register_addr, 1'b1, 32'h0000_FFFF);
    apb(cause_register_addr, 1'b0, 32'h0);
    `CHK(rd, {16'h0000, implemented_mask})
    `CHK(seen_line, 1'b0)
    `CHK(watchdog_enabled, 1'b1)
    `CHK(regulator_active, 1'b1)
    apb(source_status_addr, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0001)
    $display("test software_write done");
    apb(cause_register_addr, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(regulator_active, 1'b0)
    fuse_watchdog_enable <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(watchdog_enabled, 1'b1)
    fuse_watchdog_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(watchdog_enabled, 1'b0)
    $display("test watchdog_enable done");
    pulse(1);
    pulse(5);
    apb(cause_register_addr, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_8080)
    @(posedge pclk);
    power_on_req <= 1'b1;
    @(posedge pclk);
    power_on_req <= 1'b0;
    apb(cause_register_addr, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0003)
    $display("test persistence_power_on done");
    apb(cause_register_addr, 1'b1, 32'h0);
    low_power_active <= 1'b1;
    seen_line = 1'b0;
    pulse(3);
    `CHK(seen_line, 1'b0)
    `CHK(seen_wake, 1'b1)
    apb(cause_register_addr, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0010)
    $display("test low_power_watchdog done");
    apb(12'h008, 1'b1, 32'h0000_FFFF);
    `CHK(er, 1'b1)
    apb(12'h008, 1'b0, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, bus_zero)
    apb(cause_register_addr, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0010)
    $display("test unmapped done");
    final_report();
  end
endmodule : reset_source_combiner_tb
